// file: core/gpod_pkg.sv
package gpod_pkg;
    // ************************************************
    // bus
    // ************************************************
    localparam int unsigned AW = 12;
    localparam int unsigned DW = 32;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic HRESP_OKAY = 1'h0;
    localparam int unsigned NGRP = 5;

    // ************************************************
    // group order: card, video, sync, flash data, flash address
    // ************************************************
    localparam int unsigned G_CARD = 0;
    localparam int unsigned G_VID = 1;
    localparam int unsigned G_SYNC = 2;
    localparam int unsigned G_FDAT = 3;
    localparam int unsigned G_FADR = 4;
    localparam int unsigned CARD_W = 8;
    localparam int unsigned VID_W = 32;
    localparam int unsigned SYNC_W = 6;
    localparam int unsigned FDAT_W = 16;
    localparam int unsigned FADR_W = 25;

    // ************************************************
    // register map and fields
    // ************************************************
    localparam logic [AW-1:0] DATA_OFS [NGRP] = '{12'h090, 12'h094, 12'h098, 12'h09C, 12'h0A0};
    localparam logic [AW-1:0] SEL_OFS [NGRP] = '{12'h010, 12'h014, 12'h018, 12'h01C, 12'h020};
    localparam logic [AW-1:0] OE_OFS [NGRP] = '{12'h050, 12'h054, 12'h058, 12'h05C, 12'h060};
    localparam logic [DW-1:0] MASK [NGRP] =
        '{32'h0000_00FF, 32'hFFFF_FFFF, 32'h0000_003F, 32'h0000_FFFF, 32'h01FF_FFFF};
    localparam logic [DW-1:0] DATA_RST [NGRP] =
        '{32'h0000_0000, 32'h0000_0000, 32'h0000_0010, 32'h0000_0000, 32'h0000_0000};
    localparam logic [DW-1:0] CTRL_RST = 32'h0000_0000;
    localparam int unsigned CARD_UP_LSB = 4;
    localparam int unsigned VOUT_LSB = 8;
    localparam int unsigned S_VIN_V = 5;
    localparam int unsigned S_VIN_H = 4;
    localparam int unsigned S_ADS_V = 3;
    localparam int unsigned S_ADS_H = 2;
    localparam int unsigned S_VID_V = 1;
    localparam int unsigned S_VID_H = 0;
endpackage : gpod_pkg

// file: core/gpod_ahb_slave.sv
`timescale 1ns/10ps
module gpod_ahb_slave (
    input logic clk,
    input logic reset,
    input logic hsel,
    input logic [gpod_pkg::AW-1:0] haddr,
    input logic [1:0] htrans,
    input logic hwrite,
    input logic [2:0] hsize,
    input logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic wr_en,
    output logic rd_en,
    output logic [gpod_pkg::AW-1:0] addr
);
    logic take;
    logic next_wr;
    logic next_rd;
    logic next_rdy;
    logic [gpod_pkg::AW-1:0] next_addr;

    // reads take one wait state because hrdata is registered from the read mux in the cycle after the address phase
    always_comb begin
        take = hsel & htrans[1] & hready;
        next_wr = take & hwrite & (hsize == gpod_pkg::HSIZE_WORD);
        next_rd = take & ~hwrite;
        next_rdy = ~next_rd;
        next_addr = take ? haddr : addr;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wr_en <= 1'h0;
            rd_en <= 1'h0;
            hreadyout <= 1'h1;
            hresp <= gpod_pkg::HRESP_OKAY;
            addr <= '0;
        end else begin
            wr_en <= next_wr;
            rd_en <= next_rd;
            hreadyout <= next_rdy;
            hresp <= gpod_pkg::HRESP_OKAY;
            addr <= next_addr;
        end
    end
endmodule : gpod_ahb_slave

// file: core/gpod_pin_drive.sv
`timescale 1ns/10ps
module gpod_pin_drive #(
    parameter int unsigned W = 8
) (
    input logic clk,
    input logic reset,
    input logic [W-1:0] data,
    input logic [W-1:0] sel,
    input logic [W-1:0] oe,
    input logic [W-1:0] fn_out,
    input logic [W-1:0] fn_oe,
    output logic [W-1:0] pin_out,
    output logic [W-1:0] pin_oe
);
    logic [W-1:0] next_out;
    logic [W-1:0] next_oe;

    for (genvar i = 0; i < W; i++) begin : g_bit
        always_comb begin
            if (sel[i] && oe[i]) begin
                next_out[i] = data[i];
                next_oe[i] = 1'h1;
            end else if (sel[i]) begin
                // gpio input: data bit held but not driven
                next_out[i] = 1'h0;
                next_oe[i] = 1'h0;
            end else begin
                next_out[i] = fn_out[i];
                next_oe[i] = fn_oe[i];
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pin_out <= '0;
            pin_oe <= '0;
        end else begin
            pin_out <= next_out;
            pin_oe <= next_oe;
        end
    end
endmodule : gpod_pin_drive

// file: core/gpod_top.sv
// What this block does
// - card data lines 7..4 driven from card register bits 7..4 when gpio output
// - card data lines 3..0 driven from card register bits 3..0 when gpio output
// - 24 video output pins follow video register bits 31..8
// - eight video input pins follow video register bits 7..0
// - data bit has no pin effect unless gpio output; it only stores
// - sync bit 5 drives video-in vertical, bit 4 video-in horizontal sync
// - sync bit 3 drives display vertical, bit 2 display horizontal sync
// - sync bit 1 drives video vertical, bit 0 video horizontal sync
// - 16 flash data pins follow flash data register bits 15..0
// - 25 flash address pins follow flash address register bits 24..0
// - pin level equals stored bit: one high, zero low
// - gpio output only when selected and output enable is one
//
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/10ps
module gpod_top (
    input logic clk,
    input logic reset,
    input logic hsel,
    input logic [31:0] haddr,
    input logic [1:0] htrans,
    input logic hwrite,
    input logic [2:0] hsize,
    input logic [31:0] hwdata,
    input logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,

    // normal-function drive, from peripherals on clk
    input logic [3:0] card_upper_data_lines_fn,
    input logic [3:0] card_upper_data_lines_fn_oe,
    input logic [3:0] card_lower_data_lines_fn,
    input logic [3:0] card_lower_data_lines_fn_oe,

    input logic [23:0] video_output_bus_fn,
    input logic [23:0] video_output_bus_fn_oe,
    input logic [7:0] video_input_bus_fn,
    input logic [7:0] video_input_bus_fn_oe,

    input logic video_in_vertical_sync_fn,
    input logic video_in_vertical_sync_fn_oe,
    input logic video_in_horizontal_sync_fn,
    input logic video_in_horizontal_sync_fn_oe,
    input logic analog_display_vertical_sync_fn,
    input logic analog_display_vertical_sync_fn_oe,
    input logic analog_display_horizontal_sync_fn,
    input logic analog_display_horizontal_sync_fn_oe,
    input logic video_vertical_sync_fn,
    input logic video_vertical_sync_fn_oe,
    input logic video_horizontal_sync_fn,
    input logic video_horizontal_sync_fn_oe,

    input logic [15:0] parallel_flash_data_lines_fn,
    input logic [15:0] parallel_flash_data_lines_fn_oe,
    input logic [24:0] parallel_flash_address_lines_fn,
    input logic [24:0] parallel_flash_address_lines_fn_oe,

    // pin drive
    output logic [3:0] card_upper_data_lines,
    output logic [3:0] card_upper_data_lines_oe,
    output logic [3:0] card_lower_data_lines,
    output logic [3:0] card_lower_data_lines_oe,

    output logic [23:0] video_output_bus,
    output logic [23:0] video_output_bus_oe,
    output logic [7:0] video_input_bus,
    output logic [7:0] video_input_bus_oe,

    output logic video_in_vertical_sync,
    output logic video_in_vertical_sync_oe,
    output logic video_in_horizontal_sync,
    output logic video_in_horizontal_sync_oe,
    output logic analog_display_vertical_sync,
    output logic analog_display_vertical_sync_oe,
    output logic analog_display_horizontal_sync,
    output logic analog_display_horizontal_sync_oe,
    output logic video_vertical_sync,
    output logic video_vertical_sync_oe,
    output logic video_horizontal_sync,
    output logic video_horizontal_sync_oe,

    output logic [15:0] parallel_flash_data_lines,
    output logic [15:0] parallel_flash_data_lines_oe,
    output logic [24:0] parallel_flash_address_lines,
    output logic [24:0] parallel_flash_address_lines_oe
);
    // ************************************************
    // declarations
    // ************************************************
    localparam int unsigned NG = gpod_pkg::NGRP;

    logic wr_en;
    logic rd_en;
    logic [gpod_pkg::AW-1:0] addr;

    // one entry per pin group, in package group order
    logic [31:0] data [NG];
    logic [31:0] sel [NG];
    logic [31:0] oe [NG];

    logic [31:0] next_data [NG];
    logic [31:0] next_sel [NG];
    logic [31:0] next_oe [NG];

    logic [31:0] rmux;
    logic [31:0] next_hrdata;

    logic [gpod_pkg::CARD_W-1:0] card_pin;
    logic [gpod_pkg::CARD_W-1:0] card_pin_oe;

    logic [gpod_pkg::VID_W-1:0] vid_pin;
    logic [gpod_pkg::VID_W-1:0] vid_pin_oe;

    logic [gpod_pkg::SYNC_W-1:0] sync_pin;
    logic [gpod_pkg::SYNC_W-1:0] sync_pin_oe;

    logic [gpod_pkg::FDAT_W-1:0] fdat_pin;
    logic [gpod_pkg::FDAT_W-1:0] fdat_pin_oe;

    logic [gpod_pkg::FADR_W-1:0] fadr_pin;
    logic [gpod_pkg::FADR_W-1:0] fadr_pin_oe;

    // ************************************************
    // bus slave
    // ************************************************
    // only haddr[11:0] is decoded, so the window aliases upward
    gpod_ahb_slave u_slave (
        .clk(clk),
        .reset(reset),
        .hsel(hsel),
        .haddr(haddr[gpod_pkg::AW-1:0]),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .wr_en(wr_en),
        .rd_en(rd_en),
        .addr(addr)
    );

    // ************************************************
    // register file
    // ************************************************
    // unmapped writes fall through every compare and are dropped
    // select and enable share the data masks, so a pin keeps one bit
    // position in all three registers of its group
    always_comb begin
        for (int g = 0; g < NG; g++) begin
            next_data[g] = data[g];
            next_sel[g] = sel[g];
            next_oe[g] = oe[g];

            if (wr_en && addr == gpod_pkg::DATA_OFS[g]) begin
                next_data[g] = hwdata & gpod_pkg::MASK[g];
            end else if (wr_en && addr == gpod_pkg::SEL_OFS[g]) begin
                next_sel[g] = hwdata & gpod_pkg::MASK[g];
            end else if (wr_en && addr == gpod_pkg::OE_OFS[g]) begin
                next_oe[g] = hwdata & gpod_pkg::MASK[g];
            end
        end
    end

    // sync data leaves reset with its video-in horizontal bit set
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            for (int g = 0; g < NG; g++) begin
                data[g] <= gpod_pkg::DATA_RST[g];
                sel[g] <= gpod_pkg::CTRL_RST;
                oe[g] <= gpod_pkg::CTRL_RST;
            end
        end else begin
            for (int g = 0; g < NG; g++) begin
                data[g] <= next_data[g];
                sel[g] <= next_sel[g];
                oe[g] <= next_oe[g];
            end
        end
    end

    // ************************************************
    // read path
    // ************************************************
    // stored values are already masked, so reserved bits read zero
    always_comb begin
        rmux = 32'h0000_0000;

        for (int g = 0; g < NG; g++) begin
            if (addr == gpod_pkg::DATA_OFS[g]) begin
                rmux = data[g];
            end else if (addr == gpod_pkg::SEL_OFS[g]) begin
                rmux = sel[g];
            end else if (addr == gpod_pkg::OE_OFS[g]) begin
                rmux = oe[g];
            end
        end

        // hrdata holds between reads, as the read data must stand
        if (rd_en) begin
            next_hrdata = rmux;
        end else begin
            next_hrdata = hrdata;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            hrdata <= 32'h0000_0000;
        end else begin
            hrdata <= next_hrdata;
        end
    end

    // ************************************************
    // pin drive per group
    // ************************************************
    // concatenations list the higher register bits first
    gpod_pin_drive #(.W(gpod_pkg::CARD_W)) u_card (
        .clk(clk),
        .reset(reset),
        .data(data[gpod_pkg::G_CARD][gpod_pkg::CARD_W-1:0]),
        .sel(sel[gpod_pkg::G_CARD][gpod_pkg::CARD_W-1:0]),
        .oe(oe[gpod_pkg::G_CARD][gpod_pkg::CARD_W-1:0]),
        .fn_out({
            card_upper_data_lines_fn,
            card_lower_data_lines_fn
        }),
        .fn_oe({
            card_upper_data_lines_fn_oe,
            card_lower_data_lines_fn_oe
        }),
        .pin_out(card_pin),
        .pin_oe(card_pin_oe)
    );

    // video outputs sit above the video inputs
    gpod_pin_drive #(.W(gpod_pkg::VID_W)) u_vid (
        .clk(clk),
        .reset(reset),
        .data(data[gpod_pkg::G_VID]),
        .sel(sel[gpod_pkg::G_VID]),
        .oe(oe[gpod_pkg::G_VID]),
        .fn_out({
            video_output_bus_fn,
            video_input_bus_fn
        }),
        .fn_oe({
            video_output_bus_fn_oe,
            video_input_bus_fn_oe
        }),
        .pin_out(vid_pin),
        .pin_oe(vid_pin_oe)
    );

    // sync order: video-in pair, display pair, then video pair
    gpod_pin_drive #(.W(gpod_pkg::SYNC_W)) u_sync (
        .clk(clk),
        .reset(reset),
        .data(data[gpod_pkg::G_SYNC][gpod_pkg::SYNC_W-1:0]),
        .sel(sel[gpod_pkg::G_SYNC][gpod_pkg::SYNC_W-1:0]),
        .oe(oe[gpod_pkg::G_SYNC][gpod_pkg::SYNC_W-1:0]),
        .fn_out({
            video_in_vertical_sync_fn,
            video_in_horizontal_sync_fn,
            analog_display_vertical_sync_fn,
            analog_display_horizontal_sync_fn,
            video_vertical_sync_fn,
            video_horizontal_sync_fn
        }),
        .fn_oe({
            video_in_vertical_sync_fn_oe,
            video_in_horizontal_sync_fn_oe,
            analog_display_vertical_sync_fn_oe,
            analog_display_horizontal_sync_fn_oe,
            video_vertical_sync_fn_oe,
            video_horizontal_sync_fn_oe
        }),
        .pin_out(sync_pin),
        .pin_oe(sync_pin_oe)
    );

    // flash groups map one to one onto their register bits
    gpod_pin_drive #(.W(gpod_pkg::FDAT_W)) u_fdat (
        .clk(clk),
        .reset(reset),
        .data(data[gpod_pkg::G_FDAT][gpod_pkg::FDAT_W-1:0]),
        .sel(sel[gpod_pkg::G_FDAT][gpod_pkg::FDAT_W-1:0]),
        .oe(oe[gpod_pkg::G_FDAT][gpod_pkg::FDAT_W-1:0]),
        .fn_out(parallel_flash_data_lines_fn),
        .fn_oe(parallel_flash_data_lines_fn_oe),
        .pin_out(fdat_pin),
        .pin_oe(fdat_pin_oe)
    );

    // widest group after video: 25 address pins
    gpod_pin_drive #(.W(gpod_pkg::FADR_W)) u_fadr (
        .clk(clk),
        .reset(reset),
        .data(data[gpod_pkg::G_FADR][gpod_pkg::FADR_W-1:0]),
        .sel(sel[gpod_pkg::G_FADR][gpod_pkg::FADR_W-1:0]),
        .oe(oe[gpod_pkg::G_FADR][gpod_pkg::FADR_W-1:0]),
        .fn_out(parallel_flash_address_lines_fn),
        .fn_oe(parallel_flash_address_lines_fn_oe),
        .pin_out(fadr_pin),
        .pin_oe(fadr_pin_oe)
    );

    // ************************************************
    // pin fan-out, straight from the drive flops
    // ************************************************
    assign card_upper_data_lines = card_pin[gpod_pkg::CARD_W-1:gpod_pkg::CARD_UP_LSB];
    assign card_upper_data_lines_oe = card_pin_oe[gpod_pkg::CARD_W-1:gpod_pkg::CARD_UP_LSB];
    assign card_lower_data_lines = card_pin[gpod_pkg::CARD_UP_LSB-1:0];
    assign card_lower_data_lines_oe = card_pin_oe[gpod_pkg::CARD_UP_LSB-1:0];

    assign video_output_bus = vid_pin[gpod_pkg::VID_W-1:gpod_pkg::VOUT_LSB];
    assign video_output_bus_oe = vid_pin_oe[gpod_pkg::VID_W-1:gpod_pkg::VOUT_LSB];
    assign video_input_bus = vid_pin[gpod_pkg::VOUT_LSB-1:0];
    assign video_input_bus_oe = vid_pin_oe[gpod_pkg::VOUT_LSB-1:0];

    assign video_in_vertical_sync = sync_pin[gpod_pkg::S_VIN_V];
    assign video_in_vertical_sync_oe = sync_pin_oe[gpod_pkg::S_VIN_V];
    assign video_in_horizontal_sync = sync_pin[gpod_pkg::S_VIN_H];
    assign video_in_horizontal_sync_oe = sync_pin_oe[gpod_pkg::S_VIN_H];

    assign analog_display_vertical_sync = sync_pin[gpod_pkg::S_ADS_V];
    assign analog_display_vertical_sync_oe = sync_pin_oe[gpod_pkg::S_ADS_V];
    assign analog_display_horizontal_sync = sync_pin[gpod_pkg::S_ADS_H];
    assign analog_display_horizontal_sync_oe = sync_pin_oe[gpod_pkg::S_ADS_H];

    assign video_vertical_sync = sync_pin[gpod_pkg::S_VID_V];
    assign video_vertical_sync_oe = sync_pin_oe[gpod_pkg::S_VID_V];
    assign video_horizontal_sync = sync_pin[gpod_pkg::S_VID_H];
    assign video_horizontal_sync_oe = sync_pin_oe[gpod_pkg::S_VID_H];

    assign parallel_flash_data_lines = fdat_pin;
    assign parallel_flash_data_lines_oe = fdat_pin_oe;

    assign parallel_flash_address_lines = fadr_pin;
    assign parallel_flash_address_lines_oe = fadr_pin_oe;
endmodule : gpod_top

// file: sim/gpod_top_assertions.sv
`timescale 1ns/10ps
module gpod_top_assertions (
    input logic clk,
    input logic reset,
    input logic hsel,
    input logic [31:0] haddr,
    input logic [1:0] htrans,
    input logic hwrite,
    input logic hready,
    input logic [31:0] hrdata,
    input logic hreadyout,
    input logic hresp,
    input logic video_horizontal_sync,
    input logic video_horizontal_sync_oe,
    input logic video_horizontal_sync_fn_oe
);
    // ************************************************
    // bus and pin properties
    // ************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    logic take;
    assign take = hsel && htrans[1] && hready;
    property p_okay;
        hresp == 1'b0;
    endproperty
    a_okay: assert property (p_okay) else $error("response not okay");
    property p_rd_wait;
        take && !hwrite |=> !hreadyout ##1 hreadyout;
    endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
    property p_wr_nowait;
        take && hwrite |=> hreadyout;
    endproperty
    a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
    property p_unmapped;
        take && !hwrite && haddr[11:0] == 12'h0FC |=> ##1 hrdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_rsv_card;
        take && !hwrite && haddr[11:0] == 12'h090 |=> ##1 hrdata[31:8] == 24'h0;
    endproperty
    a_rsv_card: assert property (p_rsv_card) else $error("card reserved bits set");
    property p_rsv_sync;
        take && !hwrite && haddr[11:0] == 12'h098 |=> ##1 hrdata[31:6] == 26'h0;
    endproperty
    a_rsv_sync: assert property (p_rsv_sync) else $error("sync reserved bits set");
    property p_rsv_fdat;
        take && !hwrite && haddr[11:0] == 12'h09C |=> ##1 hrdata[31:16] == 16'h0;
    endproperty
    a_rsv_fdat: assert property (p_rsv_fdat) else $error("flash data reserved set");
    property p_rsv_fadr;
        take && !hwrite && haddr[11:0] == 12'h0A0 |=> ##1 hrdata[31:25] == 7'h0;
    endproperty
    a_rsv_fadr: assert property (p_rsv_fadr) else $error("flash addr reserved set");
    property p_stable;
        $changed(hrdata) |-> $rose(hreadyout);
    endproperty
    a_stable: assert property (p_stable) else $error("read data moved");
    // pin released while its function drove means gpio input, held low
    property p_gpin;
        !video_horizontal_sync_oe && $past(video_horizontal_sync_fn_oe) |-> !video_horizontal_sync;
    endproperty
    a_gpin: assert property (p_gpin) else $error("gpio input pin driven");
    c_write: cover property (take && hwrite);
    c_read_sync: cover property (take && !hwrite && haddr[11:0] == 12'h098);
    c_gpin: cover property (!video_horizontal_sync_oe && $past(video_horizontal_sync_fn_oe));
endmodule : gpod_top_assertions

bind gpod_top gpod_top_assertions u_chk (
    .clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .video_horizontal_sync(video_horizontal_sync),
    .video_horizontal_sync_oe(video_horizontal_sync_oe),
    .video_horizontal_sync_fn_oe(video_horizontal_sync_fn_oe)
);

// file: sim/gpio_output_data_regs_tb.sv
`timescale 1ns/10ps
module gpio_output_data_regs_tb;
    logic clk, reset, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    // all pin groups flattened in register bit order
    logic [86:0] fn, fno, pin, poe;
    logic [31:0] m [3][5];
    int n_fail, checked;
    assign hready = hreadyout;

    gpod_top dut (
        .clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp),
        .card_upper_data_lines_fn(fn[86:83]), .card_upper_data_lines_fn_oe(fno[86:83]),
        .card_lower_data_lines_fn(fn[82:79]), .card_lower_data_lines_fn_oe(fno[82:79]),
        .video_output_bus_fn(fn[78:55]), .video_output_bus_fn_oe(fno[78:55]),
        .video_input_bus_fn(fn[54:47]), .video_input_bus_fn_oe(fno[54:47]),
        .video_in_vertical_sync_fn(fn[46]), .video_in_vertical_sync_fn_oe(fno[46]),
        .video_in_horizontal_sync_fn(fn[45]), .video_in_horizontal_sync_fn_oe(fno[45]),
        .analog_display_vertical_sync_fn(fn[44]),
        .analog_display_vertical_sync_fn_oe(fno[44]),
        .analog_display_horizontal_sync_fn(fn[43]),
        .analog_display_horizontal_sync_fn_oe(fno[43]),
        .video_vertical_sync_fn(fn[42]), .video_vertical_sync_fn_oe(fno[42]),
        .video_horizontal_sync_fn(fn[41]), .video_horizontal_sync_fn_oe(fno[41]),
        .parallel_flash_data_lines_fn(fn[40:25]), .parallel_flash_data_lines_fn_oe(fno[40:25]),
        .parallel_flash_address_lines_fn(fn[24:0]),
        .parallel_flash_address_lines_fn_oe(fno[24:0]),
        .card_upper_data_lines(pin[86:83]), .card_upper_data_lines_oe(poe[86:83]),
        .card_lower_data_lines(pin[82:79]), .card_lower_data_lines_oe(poe[82:79]),
        .video_output_bus(pin[78:55]), .video_output_bus_oe(poe[78:55]),
        .video_input_bus(pin[54:47]), .video_input_bus_oe(poe[54:47]),
        .video_in_vertical_sync(pin[46]), .video_in_vertical_sync_oe(poe[46]),
        .video_in_horizontal_sync(pin[45]), .video_in_horizontal_sync_oe(poe[45]),
        .analog_display_vertical_sync(pin[44]), .analog_display_vertical_sync_oe(poe[44]),
        .analog_display_horizontal_sync(pin[43]), .analog_display_horizontal_sync_oe(poe[43]),
        .video_vertical_sync(pin[42]), .video_vertical_sync_oe(poe[42]),
        .video_horizontal_sync(pin[41]), .video_horizontal_sync_oe(poe[41]),
        .parallel_flash_data_lines(pin[40:25]), .parallel_flash_data_lines_oe(poe[40:25]),
        .parallel_flash_address_lines(pin[24:0]), .parallel_flash_address_lines_oe(poe[24:0])
    );

    // ************************************************
    // helpers
    // ************************************************
    task automatic check(input logic [86:0] got, input logic [86:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask : check

    task automatic summarize;
        $display("mismatches %0d comparisons %0d", n_fail, checked);
        if (n_fail == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : summarize

    function automatic logic [11:0] ofs(input int g, input int k);
        return k == 0 ? gpod_pkg::DATA_OFS[g] : k == 1 ? gpod_pkg::SEL_OFS[g] : gpod_pkg::OE_OFS[g];
    endfunction : ofs

    function automatic logic [86:0] pk(input logic [31:0] r [5]);
        return {r[0][7:0], r[1], r[2][5:0], r[3][15:0], r[4][24:0]};
    endfunction : pk

    task automatic xfer(input logic [11:0] a, input logic w, input logic [2:0] sz,
                        input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= sz;
        do begin
            @(posedge clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do begin
            @(posedge clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        q = hrdata;
        if (n >= 20) begin
            n_fail++;
            $display("CHECK FAILED %0t bus hang", $time);
        end
    endtask : xfer

    task automatic wr_all(input int k, input logic [31:0] v);
        logic [31:0] q;
        for (int g = 0; g < 5; g++) begin
            xfer(ofs(g, k), 1'b1, gpod_pkg::HSIZE_WORD, v, q);
            m[k][g] = v & gpod_pkg::MASK[g];
        end
    endtask : wr_all

    task automatic rd_all;
        logic [31:0] q;
        for (int k = 0; k < 3; k++) begin
            for (int g = 0; g < 5; g++) begin
                xfer(ofs(g, k), 1'b0, gpod_pkg::HSIZE_WORD, 32'h0, q);
                check({55'h0, q}, {55'h0, m[k][g]});
            end
        end
    endtask : rd_all

    // pins settle one edge after the register update
    task automatic pins;
        logic [86:0] s, o, d;
        s = pk(m[1]);
        o = pk(m[2]);
        d = pk(m[0]);
        repeat (2) @(posedge clk);
        #1;
        check(pin, (s & o & d) | (~s & fn));
        check(poe, (s & o) | (~s & fno));
        @(posedge clk);
    endtask : pins

    task automatic do_reset;
        reset <= 1'b1;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        for (int k = 0; k < 3; k++) begin
            for (int g = 0; g < 5; g++) begin
                m[k][g] = k == 0 ? gpod_pkg::DATA_RST[g] : gpod_pkg::CTRL_RST;
            end
        end
        @(posedge clk);
    endtask : do_reset

    // ************************************************
    // sequence
    // ************************************************
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        #100000;
        n_fail++;
        summarize();
    end

    initial begin
        logic [31:0] q;
        logic [31:0] pats [3];
        pats = '{32'hA5C3_5A3C, 32'h5A3C_A5C3, 32'hFFFF_FFFF};
        reset = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h0;
        hwdata = 32'h0;
        fn = {3{29'h0A5A_5A5A}};
        fno = {3{29'h1C3C_3C3C}};
        do_reset();
        rd_all();
        pins();
        wr_all(0, 32'hFFFF_FFFF);
        rd_all();
        pins();
        wr_all(1, 32'hFFFF_FFFF);
        pins();
        wr_all(2, 32'hFFFF_FFFF);
        for (int p = 0; p < 3; p++) begin
            wr_all(0, pats[p]);
            pins();
        end
        rd_all();
        wr_all(1, 32'h5555_5555);
        wr_all(2, 32'h3333_3333);
        fn <= ~fn;
        fno <= ~fno;
        pins();
        // refused: half-word write and unmapped place
        xfer(gpod_pkg::DATA_OFS[2], 1'b1, 3'h1, 32'h0000_0000, q);
        xfer(12'h0FC, 1'b1, gpod_pkg::HSIZE_WORD, 32'hFFFF_FFFF, q);
        xfer(12'h0FC, 1'b0, gpod_pkg::HSIZE_WORD, 32'h0, q);
        check({55'h0, q}, 87'h0);
        rd_all();
        do_reset();
        rd_all();
        pins();
        summarize();
    end
endmodule : gpio_output_data_regs_tb
